// ===== core/clk_input_ctrl.sv
// Purpose: Register file, source select, power-down and sync control
// Assumes: Clock pins and sync pin are asynchronous and are synchronised here
// Notes: Writes land in buffer registers; the update bit makes them active
module clk_input_ctrl #(
  parameter int NUM_CHANNELS = 3
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Register port
  input wire logic [clk_input_pkg::ADDR_W-1:0] addr_in,
  input wire logic [clk_input_pkg::DATA_W-1:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [clk_input_pkg::DATA_W-1:0] rd_data_out,
  // Clock sources and sync pin
  input wire logic vco_clk_in,
  input wire logic ext_clk_in,
  input wire logic sync_pin_n_in,
  // Channel pair settings
  input wire logic [NUM_CHANNELS-1:0] chan_nosync_in,
  input wire logic [NUM_CHANNELS-1:0] chan_bypass_in,
  // Prescaler and power controls
  output logic prescaler_clk_out,
  output logic pd_input_section_out,
  output logic pd_vco_if_out,
  output logic pd_vco_clk_out,
  output logic pd_sync_out,
  output logic pd_dist_ref_out,
  output logic cfg_conflict_out,
  // Channel sync and direct routing
  output logic [NUM_CHANNELS-1:0] chan_sync_hold_out,
  output logic [NUM_CHANNELS-1:0] chan_sync_pulse_out,
  output logic [NUM_CHANNELS-1:0] chan_direct_vco_out,
  output logic [NUM_CHANNELS-1:0] chan_direct_ext_out
);

  if (NUM_CHANNELS < 1 || NUM_CHANNELS > 8)
  begin : g_bad_channels
    $error("NUM_CHANNELS must be between 1 and 8");
  end

  if (clk_input_pkg::DATA_W < clk_input_pkg::PD_INPUT_BIT + 1 || clk_input_pkg::RATIO_W != 3)
  begin : g_bad_widths
    $error("register fields must fit the data width");
  end

  // Buffer registers, as software last wrote them
  logic [2:0] buf_ratio;
  logic [4:0] buf_input;
  logic [2:0] buf_system;
  // Active registers, steering the hardware
  logic [2:0] act_ratio;
  logic [4:0] act_input;
  logic [2:0] act_system;
  logic update_pend;

  // Synchronisers: first stage feeds only the second stage
  logic [2:0] pin_meta;
  logic [2:0] pin_sync;
  logic src_prev;
  logic src_level;
  logic sync_req_prev;
  logic sync_req;
  logic sync_fall;

  logic wr_ratio;
  logic wr_input;
  logic wr_system;
  logic wr_update_set;
  logic next_update_pend;
  logic [clk_input_pkg::DATA_W-1:0] next_rd_data;

  logic bypass_act;
  logic vco_sel_act;
  logic src_powered;
  logic path_powered;
  logic prescaler_static;
  logic copy_now;
  logic pin_sync_req;
  logic soft_sync_req;
  logic sync_powered;
  logic direct_vco_code;
  logic direct_ext_code;
  logic [clk_input_pkg::DATA_W-1:0] status_word;

  prescaler_if pif ();

  // Register writes into the buffer set
  assign wr_ratio = wr_in && (addr_in == clk_input_pkg::PRESCALER_RATIO_ADDR);
  assign wr_input = wr_in && (addr_in == clk_input_pkg::INPUT_SOURCE_AND_POWER_ADDR);
  assign wr_system = wr_in && (addr_in == clk_input_pkg::SYSTEM_POWER_AND_SYNC_ADDR);
  assign wr_update_set = wr_in && (addr_in == clk_input_pkg::UPDATE_STROBE_ADDR)
    && wr_data_in[clk_input_pkg::UPDATE_BIT];

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      buf_ratio <= clk_input_pkg::RATIO_RESET;
    else if (wr_ratio)
      buf_ratio <= wr_data_in[2:0];
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      buf_input <= clk_input_pkg::INPUT_RESET;
    else if (wr_input)
      buf_input <= wr_data_in[4:0];
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      buf_system <= clk_input_pkg::SYSTEM_RESET;
    else if (wr_system)
      buf_system <= wr_data_in[2:0];
  end

  // Update request: a new write of 1 wins over the self-clear
  always_comb
  begin
    next_update_pend = 1'b0;
    if (wr_update_set)
      next_update_pend = 1'b1;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      update_pend <= 1'b0;
    else
      update_pend <= next_update_pend;
  end

  // Copy the buffer set while the request stands; all three move on the same edge
  assign copy_now = update_pend;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      act_ratio <= clk_input_pkg::RATIO_RESET;
    else if (copy_now)
      act_ratio <= buf_ratio;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      act_input <= clk_input_pkg::INPUT_RESET;
    else if (copy_now)
      act_input <= buf_input;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      act_system <= clk_input_pkg::SYSTEM_RESET;
    else if (copy_now)
      act_system <= buf_system;
  end

  // Status word, assembled from live state
  always_comb
  begin
    status_word = '0;
    status_word[clk_input_pkg::ST_DIV_OUT_BIT] = pif.div_level;
    status_word[clk_input_pkg::ST_SYNC_HOLD_BIT] = sync_req;
    status_word[clk_input_pkg::ST_CONFLICT_BIT] = cfg_conflict_out;
    status_word[clk_input_pkg::ST_UPDATE_BIT] = update_pend;
  end

  // Read data, valid in the cycle after the strobe
  always_comb
  begin
    next_rd_data = '0;
    case (addr_in)
      clk_input_pkg::PRESCALER_RATIO_ADDR:
        next_rd_data[2:0] = buf_ratio;
      clk_input_pkg::INPUT_SOURCE_AND_POWER_ADDR:
        next_rd_data[4:0] = buf_input;
      clk_input_pkg::SYSTEM_POWER_AND_SYNC_ADDR:
        next_rd_data[2:0] = buf_system;
      clk_input_pkg::UPDATE_STROBE_ADDR:
        next_rd_data[clk_input_pkg::UPDATE_BIT] = update_pend;
      clk_input_pkg::BLOCK_STATUS_ADDR:
        next_rd_data = status_word;
      default:
        next_rd_data = '0;
    endcase
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      rd_data_out <= '0;
    else if (rd_in)
      rd_data_out <= next_rd_data;
    else
      rd_data_out <= '0;
  end

  // Pin synchronisers
  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
    begin
      pin_meta <= 3'h4;
      pin_sync <= 3'h4;
    end
    else
    begin
      pin_meta <= {sync_pin_n_in, ext_clk_in, vco_clk_in};
      pin_sync <= pin_meta;
    end
  end

  // Source decode
  assign bypass_act = act_input[clk_input_pkg::BYPASS_BIT];
  assign vco_sel_act = act_input[clk_input_pkg::VCO_SEL_BIT];
  // Bypass with the VCO selected is illegal; flag it and keep dividing
  assign cfg_conflict_out = bypass_act && vco_sel_act;
  assign src_powered = !act_input[clk_input_pkg::PD_VCO_CLK_BIT];
  assign path_powered = !act_input[clk_input_pkg::PD_INPUT_BIT]
    && !(vco_sel_act && act_input[clk_input_pkg::PD_VCO_IF_BIT]);
  assign prescaler_static = (act_ratio > clk_input_pkg::RATIO_LAST_DIVIDE);

  always_comb
  begin
    src_level = 1'b0;
    if (src_powered)
    begin
      if (vco_sel_act)
        src_level = pin_sync[0];
      else
        src_level = pin_sync[1];
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      src_prev <= 1'b0;
    else
      src_prev <= src_level;
  end

  // Prescaler settings
  assign pif.src_level = src_level;
  assign pif.src_rise = src_level && !src_prev;
  assign pif.run = path_powered && src_powered;
  assign pif.bypass = bypass_act && !vco_sel_act;
  assign pif.static_hold = prescaler_static;
  assign pif.ratio_code = prescaler_static ? clk_input_pkg::RATIO_RESET : act_ratio;

  prescaler_div u_prescaler (
    .mclk_in(mclk_in),
    .srst_in(srst_in),
    .pif(pif)
  );

  assign prescaler_clk_out = pif.div_level;

  // Power-down outputs straight from the active set
  assign pd_input_section_out = act_input[clk_input_pkg::PD_INPUT_BIT];
  assign pd_vco_if_out = act_input[clk_input_pkg::PD_VCO_IF_BIT];
  assign pd_vco_clk_out = act_input[clk_input_pkg::PD_VCO_CLK_BIT];
  assign pd_sync_out = act_system[clk_input_pkg::PD_SYNC_BIT];
  assign pd_dist_ref_out = act_system[clk_input_pkg::PD_DIST_REF_BIT];

  // Sync request: pin low or soft bit high, unless sync is powered down
  assign sync_powered = !act_system[clk_input_pkg::PD_SYNC_BIT];
  assign pin_sync_req = !pin_sync[2];
  assign soft_sync_req = act_system[clk_input_pkg::SOFT_SYNC_BIT];

  always_comb
  begin
    sync_req = 1'b0;
    if (sync_powered)
      sync_req = pin_sync_req || soft_sync_req;
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in)
      sync_req_prev <= 1'b0;
    else
      sync_req_prev <= sync_req;
  end

  // Release of the request fires the sync; powering sync down mid-hold must not
  assign sync_fall = sync_req_prev && !sync_req && sync_powered;

  // Code 01b and the illegal 11b route nothing
  assign direct_vco_code = (act_input[clk_input_pkg::VCO_SEL_BIT:clk_input_pkg::BYPASS_BIT]
    == clk_input_pkg::DIRECT_VCO_CODE);
  assign direct_ext_code = (act_input[clk_input_pkg::VCO_SEL_BIT:clk_input_pkg::BYPASS_BIT]
    == clk_input_pkg::DIRECT_EXT_CODE);

  // One slice per channel pair: sync gating and direct routing
  for (genvar ch = 0; ch < NUM_CHANNELS; ch++)
  begin : g_chan
    logic sync_hold;
    logic sync_pulse;
    logic route_vco;
    logic route_ext;

    always_ff @(posedge mclk_in)
    begin
      if (srst_in)
        sync_hold <= 1'b0;
      else
        sync_hold <= sync_req && !chan_nosync_in[ch];
    end

    always_ff @(posedge mclk_in)
    begin
      if (srst_in)
        sync_pulse <= 1'b0;
      else
        sync_pulse <= sync_fall && !chan_nosync_in[ch];
    end

    always_ff @(posedge mclk_in)
    begin
      if (srst_in)
        route_vco <= 1'b0;
      else
        route_vco <= chan_bypass_in[ch] && direct_vco_code;
    end

    always_ff @(posedge mclk_in)
    begin
      if (srst_in)
        route_ext <= 1'b0;
      else
        route_ext <= chan_bypass_in[ch] && direct_ext_code;
    end

    assign chan_sync_hold_out[ch] = sync_hold;
    assign chan_sync_pulse_out[ch] = sync_pulse;
    assign chan_direct_vco_out[ch] = route_vco;
    assign chan_direct_ext_out[ch] = route_ext;
  end

endmodule : clk_input_ctrl

// ===== core/clk_input_pkg.sv
// Purpose: Constants for the clock input, prescaler and sync control block
// Assumes: 8-bit register data, 10-bit register address, 100 MHz mclk_in
package clk_input_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int RATIO_W = 3;
  // Register offsets
  localparam logic [9:0] PRESCALER_RATIO_ADDR = 10'h1E0;
  localparam logic [9:0] INPUT_SOURCE_AND_POWER_ADDR = 10'h1E1;
  localparam logic [9:0] SYSTEM_POWER_AND_SYNC_ADDR = 10'h230;
  localparam logic [9:0] UPDATE_STROBE_ADDR = 10'h232;
  localparam logic [9:0] BLOCK_STATUS_ADDR = 10'h233;
  // Prescaler ratio field
  localparam logic [2:0] RATIO_RESET = 3'h2;
  localparam logic [2:0] RATIO_LAST_DIVIDE = 3'h4;
  localparam logic [2:0] RATIO_OFFSET = 3'h2;
  // Input source and power bits
  localparam int BYPASS_BIT = 0;
  localparam int VCO_SEL_BIT = 1;
  localparam int PD_VCO_CLK_BIT = 2;
  localparam int PD_VCO_IF_BIT = 3;
  localparam int PD_INPUT_BIT = 4;
  localparam logic [4:0] INPUT_RESET = 5'h00;
  // System bits
  localparam int SOFT_SYNC_BIT = 0;
  localparam int PD_DIST_REF_BIT = 1;
  localparam int PD_SYNC_BIT = 2;
  localparam logic [2:0] SYSTEM_RESET = 3'h0;
  // Update bit
  localparam int UPDATE_BIT = 0;
  // Status bits
  localparam int ST_DIV_OUT_BIT = 0;
  localparam int ST_SYNC_HOLD_BIT = 1;
  localparam int ST_CONFLICT_BIT = 2;
  localparam int ST_UPDATE_BIT = 3;
  // Source select codes seen by bypassed channel pairs
  localparam logic [1:0] DIRECT_VCO_CODE = 2'h2;
  localparam logic [1:0] DIRECT_EXT_CODE = 2'h0;
endpackage : clk_input_pkg

// ===== core/prescaler_if.sv
// Purpose: Carrier between the control logic and the prescaler
// Assumes: Single clock domain, source edge already synchronised
// Notes: ctrl drives the settings, div returns the divided level
interface prescaler_if;
  logic src_level;
  logic src_rise;
  logic run;
  logic bypass;
  logic static_hold;
  logic [clk_input_pkg::RATIO_W-1:0] ratio_code;
  logic div_level;
  modport ctrl (
    output src_level, src_rise, run, bypass, static_hold, ratio_code,
    input div_level
  );
  modport div (
    input src_level, src_rise, run, bypass, static_hold, ratio_code,
    output div_level
  );
endinterface : prescaler_if

// ===== core/prescaler_div.sv
// Purpose: Divide the selected source by 2 to 6, bypass it or hold it static
// Assumes: src_rise is a one-cycle pulse per source rising edge
// Notes: Odd ratios give an uneven duty cycle; only the period is exact
module prescaler_div (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Settings and result
  prescaler_if.div pif
);
  logic [clk_input_pkg::RATIO_W-1:0] count;
  logic [clk_input_pkg::RATIO_W-1:0] ratio;
  logic [clk_input_pkg::RATIO_W-1:0] half;

  assign ratio = pif.ratio_code + clk_input_pkg::RATIO_OFFSET;
  assign half = ratio >> 1;

  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !pif.run || pif.static_hold)
      count <= '0;
    else if (pif.src_rise)
    begin
      if (count >= ratio - 3'h1)
        count <= '0;
      else
        count <= count + 3'h1;
    end
  end

  always_ff @(posedge mclk_in)
  begin
    if (srst_in || !pif.run)
      pif.div_level <= 1'b0;
    else if (pif.bypass)
      pif.div_level <= pif.src_level;
    else if (pif.static_hold)
      pif.div_level <= 1'b0;
    else
      pif.div_level <= (count >= half);
  end
endmodule : prescaler_div

// ===== tb/clk_input_ctrl_assertions.sv
// Purpose: Port checks for clk_input_ctrl
// Assumes: chan_nosync_in steady around sync activity
// Notes: Bound to every clk_input_ctrl instance
module clk_input_ctrl_assertions #(
  parameter int NUM_CHANNELS = 3
) (
  // Clock and reset
  input wire logic mclk_in,
  input wire logic srst_in,
  // Watched ports
  input wire logic [NUM_CHANNELS-1:0] chan_nosync_in,
  input wire logic [NUM_CHANNELS-1:0] chan_bypass_in,
  input wire logic prescaler_clk_out,
  input wire logic pd_input_section_out,
  input wire logic pd_vco_clk_out,
  input wire logic pd_sync_out,
  input wire logic cfg_conflict_out,
  input wire logic [NUM_CHANNELS-1:0] chan_sync_hold_out,
  input wire logic [NUM_CHANNELS-1:0] chan_sync_pulse_out,
  input wire logic [NUM_CHANNELS-1:0] chan_direct_vco_out,
  input wire logic [NUM_CHANNELS-1:0] chan_direct_ext_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (srst_in);
  // Three cycles allow for the prescaler output register
  sequence s_run_off;
    (pd_input_section_out || pd_vco_clk_out) [*3];
  endsequence
  a_hold_nosync: assert property (!(|(chan_sync_hold_out & $past(chan_nosync_in))))
    else $error("sync hold on a nosync channel");
  a_pulse_nosync: assert property (!(|(chan_sync_pulse_out & $past(chan_nosync_in))))
    else $error("sync pulse on a nosync channel");
  a_pulse_after_hold: assert property (
    !(|(chan_sync_pulse_out & ~$past(chan_sync_hold_out))))
    else $error("sync pulse without prior hold");
  a_pulse_single: assert property ((|chan_sync_pulse_out) |=> !(|chan_sync_pulse_out))
    else $error("sync pulse longer than one cycle");
  a_direct_excl: assert property (!(|(chan_direct_vco_out & chan_direct_ext_out)))
    else $error("both direct routes active");
  a_direct_bypass: assert property (
    !(|((chan_direct_vco_out | chan_direct_ext_out) & ~$past(chan_bypass_in))))
    else $error("direct route without channel bypass");
  a_conflict_no_direct: assert property (
    cfg_conflict_out ##1 cfg_conflict_out |-> !(|(chan_direct_vco_out | chan_direct_ext_out)))
    else $error("direct route with code 11");
  a_input_pd_stops: assert property (s_run_off |-> !prescaler_clk_out)
    else $error("prescaler runs while powered down");
  a_sync_pd_quiet: assert property (
    pd_sync_out [*4] |-> !(|chan_sync_hold_out) && !(|chan_sync_pulse_out))
    else $error("sync active while powered down");
endmodule : clk_input_ctrl_assertions

bind clk_input_ctrl clk_input_ctrl_assertions #(.NUM_CHANNELS(NUM_CHANNELS)) u_chk (
  .mclk_in(mclk_in), .srst_in(srst_in), .chan_nosync_in(chan_nosync_in),
  .chan_bypass_in(chan_bypass_in), .prescaler_clk_out(prescaler_clk_out),
  .pd_input_section_out(pd_input_section_out), .pd_vco_clk_out(pd_vco_clk_out),
  .pd_sync_out(pd_sync_out), .cfg_conflict_out(cfg_conflict_out),
  .chan_sync_hold_out(chan_sync_hold_out), .chan_sync_pulse_out(chan_sync_pulse_out),
  .chan_direct_vco_out(chan_direct_vco_out), .chan_direct_ext_out(chan_direct_ext_out));

// ===== tb/tb.sv
// Purpose: Self-checking bench for clk_input_ctrl
// Assumes: Ext clock period 4 cycles, VCO period 6 cycles
// Notes: Periods are counted in mclk_in cycles between rises
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in, srst_in, wr_in, rd_in, vco_clk_in, ext_clk_in, sync_pin_n_in;
  logic [9:0] addr_in;
  logic [7:0] wr_data_in, rd_data_out;
  logic [2:0] nosync, bypass, hold, pulse, dvco, dext, caught;
  logic presc, pd_in, pd_if, pd_vc, pd_sy, pd_dr, conflict;
  int err_total, n_tests, i;

  clk_input_ctrl #(.NUM_CHANNELS(3)) u_dut (
    .mclk_in(mclk_in), .srst_in(srst_in), .addr_in(addr_in), .wr_data_in(wr_data_in),
    .wr_in(wr_in), .rd_in(rd_in), .rd_data_out(rd_data_out), .vco_clk_in(vco_clk_in),
    .ext_clk_in(ext_clk_in), .sync_pin_n_in(sync_pin_n_in), .chan_nosync_in(nosync),
    .chan_bypass_in(bypass), .prescaler_clk_out(presc), .pd_input_section_out(pd_in),
    .pd_vco_if_out(pd_if), .pd_vco_clk_out(pd_vc), .pd_sync_out(pd_sy),
    .pd_dist_ref_out(pd_dr), .cfg_conflict_out(conflict), .chan_sync_hold_out(hold),
    .chan_sync_pulse_out(pulse), .chan_direct_vco_out(dvco), .chan_direct_ext_out(dext));

  initial
  begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end
  // Sources run free, unrelated to any register access
  initial
  begin
    ext_clk_in = 1'b0;
    forever
    begin
      repeat (2) @(posedge mclk_in);
      ext_clk_in <= ~ext_clk_in;
    end
  end
  initial
  begin
    vco_clk_in = 1'b0;
    forever
    begin
      repeat (3) @(posedge mclk_in);
      vco_clk_in <= ~vco_clk_in;
    end
  end
  always @(posedge mclk_in) caught <= caught | pulse;

  task chk(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= d;
    @(posedge mclk_in);
    wr_in <= 1'b0;
  endtask : wr
  task rd(input logic [9:0] a, input logic [7:0] exp, input string name);
    @(posedge mclk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge mclk_in);
    rd_in <= 1'b0;
    #1;
    chk(name, rd_data_out, exp);
  endtask : rd
  // Update, then let the copy and output registers settle
  task upd(input logic [9:0] a, input logic [7:0] d);
    wr(a, d);
    wr(10'h232, 8'h01);
    repeat (6) @(posedge mclk_in);
    #1;
  endtask : upd
  task rise_gap(output logic [7:0] n);
    logic prev;
    n = 8'h00;
    prev = presc;
    for (int k = 1; k < 100; k++)
    begin
      @(posedge mclk_in);
      #1;
      if (!prev && presc)
      begin
        n = 8'(k);
        break;
      end
      prev = presc;
    end
  endtask : rise_gap
  // First gap is partial, second is one full period; 0 means no rise
  task period(input logic [7:0] exp, input string name);
    logic [7:0] n;
    rise_gap(n);
    rise_gap(n);
    chk(name, n, exp);
  endtask : period

  task t_reset;
    rd(10'h1E0, 8'h02, "ratio reset");
    rd(10'h1E1, 8'h00, "input reset");
    rd(10'h230, 8'h00, "system reset");
    rd(10'h232, 8'h00, "update reset");
    rd(10'h100, 8'h00, "unmapped");
    chk("power", {3'h0, pd_in, pd_if, pd_vc, pd_sy, pd_dr}, 8'h00);
    chk("direct ext", {5'h00, dext}, {5'h00, bypass});
    period(8'd16, "default period");
    $display("test reset done");
  endtask : t_reset
  task t_ratio;
    for (i = 0; i < 8; i++)
    begin
      upd(10'h1E0, 8'(i));
      period((i < 5) ? 8'((i + 2) * 4) : 8'h00, "ratio period");
    end
    $display("test ratio done");
  endtask : t_ratio
  task t_source;
    upd(10'h1E0, 8'h00);
    upd(10'h1E1, 8'h02);
    period(8'd12, "vco period");
    chk("direct vco", {5'h00, dvco}, {5'h00, bypass});
    upd(10'h1E1, 8'h01);
    period(8'd4, "bypass period");
    chk("direct none", {5'h00, dvco | dext}, 8'h00);
    upd(10'h1E1, 8'h03);
    chk("conflict", {7'h00, conflict}, 8'h01);
    wr(10'h1E1, 8'h10);
    repeat (4) @(posedge mclk_in);
    #1;
    chk("buffered only", {7'h00, pd_in}, 8'h00);
    upd(10'h1E1, 8'h10);
    chk("pd input", {7'h00, pd_in}, 8'h01);
    period(8'h00, "pd input period");
    rd(10'h232, 8'h00, "update clear");
    upd(10'h1E1, 8'h04);
    chk("pd clk", {7'h00, pd_vc}, 8'h01);
    period(8'h00, "pd clk period");
    upd(10'h1E1, 8'h0A);
    chk("pd if", {7'h00, pd_if}, 8'h01);
    period(8'h00, "pd if period");
    $display("test source done");
  endtask : t_source
  task t_sync;
    @(posedge mclk_in);
    sync_pin_n_in <= 1'b0;
    repeat (6) @(posedge mclk_in);
    #1;
    chk("pin hold", {5'h00, hold}, 8'h05);
    caught = 3'h0;
    @(posedge mclk_in);
    sync_pin_n_in <= 1'b1;
    repeat (8) @(posedge mclk_in);
    #1;
    chk("pin pulse", {5'h00, caught}, 8'h05);
    upd(10'h230, 8'h01);
    chk("soft hold", {5'h00, hold}, 8'h05);
    rd(10'h233, 8'h02, "status hold");
    caught = 3'h0;
    upd(10'h230, 8'h00);
    chk("soft pulse", {5'h00, caught}, 8'h05);
    upd(10'h230, 8'h01);
    caught = 3'h0;
    upd(10'h230, 8'h05);
    chk("pd sync", {5'h00, pd_sy, |hold, |caught}, 8'h04);
    caught = 3'h0;
    upd(10'h230, 8'h02);
    chk("pd ref", {5'h00, pd_dr, pd_sy, |caught}, 8'h04);
    $display("test sync done");
  endtask : t_sync

  task conclude;
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge mclk_in);
    err_total++;
    conclude();
  end
  initial
  begin
    err_total = 0;
    n_tests = 0;
    srst_in = 1'b1;
    {wr_in, rd_in, addr_in, wr_data_in} = '0;
    sync_pin_n_in = 1'b1;
    nosync = 3'h2;
    bypass = 3'h3;
    caught = 3'h0;
    repeat (20) @(posedge mclk_in);
    srst_in <= 1'b0;
    t_reset();
    t_ratio();
    t_source();
    t_sync();
    conclude();
  end
endmodule : tb
